// ### board_model.sv
module board_model #(
  parameter int RST_LOW = 4064,
  parameter int IRQ_GAP = 21
) (
  input  wire logic clk,
  output logic      rst_n,
  output logic      irq_high_voltage,
  output logic      mode_strap_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board starts in reset with straps idle
  initial begin
    rst_n = 1'b0;
    irq_high_voltage = 1'b0;
    mode_strap_pin = 1'b0;
  end
  // Long reset covers a power-up, the worst case for entry
  task automatic power_up(input logic irq, input logic strap);
    @(negedge clk);
    rst_n = 1'b0;
    irq_high_voltage = irq;
    mode_strap_pin = strap;
    repeat (RST_LOW) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    irq_high_voltage = ~irq; // Freed pins now carry other traffic
    mode_strap_pin = ~strap;
    // No service routine runs here, so the bare margin sets the spacing
    repeat (IRQ_GAP) @(negedge clk);
    irq_high_voltage = irq;
  endtask
endmodule

// ### mode_pkg.sv
package mode_pkg;
  localparam logic [15:0] TEST_START     = 16'h3F00;
  localparam logic [15:0] TEST_END       = 16'h3FDF;
  localparam int          LATCH_CYCLES   = 2;
  localparam logic [2:0]  LED_ALL_OFF    = 3'h7;
  localparam logic [2:0]  LED_BAD_IO     = 3'h6;
  localparam logic [2:0]  LED_BAD_RAM    = 3'h5;
  localparam logic [2:0]  LED_BAD_ROM    = 3'h4;
  localparam logic [2:0]  LED_BAD_IRQ    = 3'h3;
  localparam logic [2:0]  LED_ALL_ON     = 3'h0;
  localparam int          FLASH_NS       = 1000;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          FLASH_CYCLES   = (FLASH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FAIL_IO,
    FAIL_RAM,
    FAIL_ROM,
    FAIL_IRQ
  } fail_kind_t;

  typedef struct packed {
    logic       valid;
    fail_kind_t kind;
  } fail_report_t;

  typedef enum {
    ST_SAMPLE,
    ST_USER,
    ST_CHECK,
    ST_FAILED
  } mode_state_t;
endpackage

// ### reset_mode_select_selfcheck.sv
module reset_mode_select_selfcheck #(
  parameter bit IS_EPROM_PART = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   irq_high_voltage,
  input  wire logic                   mode_strap_pin,
  input  wire mode_pkg::fail_report_t test_fail,
  input  wire logic                   test_pass,
  output logic                        user_mode,
  output logic                        selfcheck_mode,
  output logic                        bootstrap_mode,
  output logic                        strap_released,
  output logic [15:0]                 start_vector,
  output logic                        report_led_bit3,
  output logic                        report_led_bit1,
  output logic                        report_led_bit0
);
  import mode_pkg::*;

  // Pin synchronisers; first stage read only by second
  logic [1:0]  hv_sync_q;
  logic [1:0]  strap_sync_q;
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  mode_state_t state_q;
  mode_state_t state_d;
  logic [2:0]  led_q;
  logic [2:0]  led_d;
  logic [2:0]  fail_code;
  logic        enter_check;
  logic        decide_now;
  logic        in_check;
  logic [2:0]  age_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_sync_q    <= 2'h0;
      strap_sync_q <= 2'h0;
    end else begin
      hv_sync_q    <= {hv_sync_q[0], irq_high_voltage};
      strap_sync_q <= {strap_sync_q[0], mode_strap_pin};
    end
  end

  // Decide at end of sampling; both pins must be high
  assign enter_check = hv_sync_q[1] & strap_sync_q[1];
  // Pins caught at the first edge need one more to clear the synchroniser,
  // so the choice waits for the saturated count, never on reset zeros
  assign decide_now  = (cnt_q == 2'(LATCH_CYCLES));
  assign cnt_d       = decide_now ? cnt_q : cnt_q + 2'h1;
  // Check and failed states both occupy the self-check slot
  assign in_check    = (state_d == ST_CHECK) || (state_d == ST_FAILED);

  // Failure code lookup, 1 means LED off
  assign fail_code = (test_fail.kind == FAIL_IO)  ? LED_BAD_IO  :
                     (test_fail.kind == FAIL_RAM) ? LED_BAD_RAM :
                     (test_fail.kind == FAIL_ROM) ? LED_BAD_ROM : LED_BAD_IRQ;

  // Mode chosen once; later pin activity ignored
  always_comb begin
    state_d = state_q;
    led_d   = led_q;
    case (state_q)
      ST_SAMPLE: begin
        if (decide_now) begin
          state_d = enter_check ? ST_CHECK : ST_USER;
        end
      end
      ST_USER: state_d = ST_USER;
      ST_CHECK: begin
        // Failure outranks a pass arriving in the same cycle
        if (test_fail.valid) begin
          state_d = ST_FAILED;
          led_d   = fail_code;
        end else if (test_pass) begin
          led_d = ~led_q;
        end
      end
      ST_FAILED: state_d = ST_FAILED;
      default: state_d = ST_SAMPLE;
    endcase
  end

  // Sample counter only runs right after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= 2'h0;
      state_q <= ST_SAMPLE;
      led_q   <= LED_ALL_OFF;
    end else begin
      cnt_q   <= cnt_d;
      state_q <= state_d;
      led_q   <= led_d;
    end
  end

  // Own edge count since release, read by the timing checks only;
  // kept apart from cnt_q so the checks do not trust the logic they judge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_q <= 3'h0;
    end else begin
      age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
    end
  end

  // Registered outputs; variant picks bootstrap vs self-check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_mode       <= 1'b0;
      selfcheck_mode  <= 1'b0;
      bootstrap_mode  <= 1'b0;
      strap_released  <= 1'b0;
      start_vector    <= 16'h0000;
      report_led_bit3 <= 1'b1;
      report_led_bit1 <= 1'b1;
      report_led_bit0 <= 1'b1;
    end else begin
      user_mode       <= (state_d == ST_USER);
      selfcheck_mode  <= !IS_EPROM_PART && in_check;
      bootstrap_mode  <= IS_EPROM_PART && in_check;
      strap_released  <= (state_d != ST_SAMPLE);
      start_vector    <= (state_d == ST_CHECK || state_d == ST_FAILED) ? TEST_START
                                                                     : 16'h0000;
      report_led_bit3 <= led_d[2];
      report_led_bit1 <= led_d[1];
      report_led_bit0 <= led_d[0];
    end
  end

  // Core checks on mode, timing, vector and report pins
  mode_one_hot_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(user_mode && (selfcheck_mode || bootstrap_mode)))
    else $error("both modes active");
  mode_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(user_mode) |=> user_mode [*8])
    else $error("user mode dropped");
  decide_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strap_released) |-> cnt_q == 2'(LATCH_CYCLES))
    else $error("strap released at wrong time");
  led_flash_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_CHECK && test_pass && !test_fail.valid)
      |=> report_led_bit0 != $past(report_led_bit0))
    else $error("leds did not toggle");
  fail_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_CHECK && test_fail.valid && test_fail.kind == FAIL_RAM)
      |=> {report_led_bit3, report_led_bit1, report_led_bit0} == LED_BAD_RAM)
    else $error("wrong ram code");
  vector_a: assert property (@(posedge clk) disable iff (!rst_n)
    (selfcheck_mode || bootstrap_mode) |-> start_vector == TEST_START)
    else $error("wrong test vector");
  variant_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(selfcheck_mode && bootstrap_mode))
    else $error("both variant modes");
  fail_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_FAILED |=> $stable({report_led_bit3, report_led_bit1, report_led_bit0}))
    else $error("fail pattern changed");

  // No mode before the choice; variant decides the slot name
  mode_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !strap_released |-> !(user_mode || selfcheck_mode || bootstrap_mode))
    else $error("mode shown before choice");
  variant_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (selfcheck_mode || bootstrap_mode) |-> bootstrap_mode == IS_EPROM_PART)
    else $error("wrong variant slot");

  // Chosen mode must match the pins seen at the decision edge
  check_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strap_released) |-> (selfcheck_mode || bootstrap_mode) == $past(enter_check))
    else $error("check slot mismatch");
  user_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strap_released) |-> user_mode == !$past(enter_check))
    else $error("user mode mismatch");

  // Strap hand-over lands on a fixed edge after release
  release_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strap_released) |-> age_q == 3'(LATCH_CYCLES + 1))
    else $error("strap freed at wrong edge");
  strap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (age_q <= 3'(LATCH_CYCLES)) |-> !strap_released)
    else $error("strap freed too early");

  // Later pin traffic never moves the chosen mode
  mode_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
    strap_released |=> $stable({user_mode, selfcheck_mode, bootstrap_mode}))
    else $error("mode changed after choice");

  // Vector is zero outside the slot and inside the test region in it
  vector_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(selfcheck_mode || bootstrap_mode) |-> start_vector == 16'h0000)
    else $error("vector outside slot");
  vector_region_a: assert property (@(posedge clk) disable iff (!rst_n)
    (start_vector != 16'h0000) |-> (start_vector >= TEST_START && start_vector <= TEST_END))
    else $error("vector outside region");

  // Every report pin flashes; pins stay dark outside self-check
  bit1_flash_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_CHECK && test_pass && !test_fail.valid)
      |=> report_led_bit1 != $past(report_led_bit1))
    else $error("bit1 did not toggle");
  bit3_flash_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_CHECK && test_pass && !test_fail.valid)
      |=> report_led_bit3 != $past(report_led_bit3))
    else $error("bit3 did not toggle");
  led_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    user_mode |-> {report_led_bit3, report_led_bit1, report_led_bit0} == LED_ALL_OFF)
    else $error("leds lit in user mode");
  sample_dark_a: assert property (@(posedge clk) disable iff (!rst_n)
    !strap_released |-> {report_led_bit3, report_led_bit1, report_led_bit0} == LED_ALL_OFF)
    else $error("leds lit before choice");
  led_user_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    user_mode |=> $stable({report_led_bit3, report_led_bit1, report_led_bit0}))
    else $error("leds moved in user mode");

  // Remaining failure codes, one per kind
  fail_io_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_CHECK && test_fail.valid && test_fail.kind == FAIL_IO)
      |=> {report_led_bit3, report_led_bit1, report_led_bit0} == LED_BAD_IO)
    else $error("wrong io code");
  fail_rom_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_CHECK && test_fail.valid && test_fail.kind == FAIL_ROM)
      |=> {report_led_bit3, report_led_bit1, report_led_bit0} == LED_BAD_ROM)
    else $error("wrong rom code");
  fail_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_CHECK && test_fail.valid && test_fail.kind == FAIL_IRQ)
      |=> {report_led_bit3, report_led_bit1, report_led_bit0} == LED_BAD_IRQ)
    else $error("wrong irq code");
endmodule

// ### reset_mode_select_selfcheck_bench.sv
module reset_mode_select_selfcheck_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mode_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n, irq_high_voltage, mode_strap_pin;
  logic         user_mode, selfcheck_mode, bootstrap_mode, strap_released;
  logic [15:0]  start_vector;
  logic         led3, led1, led0;
  fail_report_t test_fail = '0;
  logic         test_pass = 1'b0;
  int           num_errors = 0;
  int           check_count = 0;
  wire [2:0]    leds = {led3, led1, led0};
  logic [2:0]   codes [4] = '{LED_BAD_IO, LED_BAD_RAM, LED_BAD_ROM, LED_BAD_IRQ};
  always #2 clk = ~clk;
  board_model u_board_model (.clk(clk), .rst_n(rst_n), .irq_high_voltage(irq_high_voltage),
    .mode_strap_pin(mode_strap_pin));
  reset_mode_select_selfcheck u_reset_mode_select_selfcheck (.clk(clk), .rst_n(rst_n),
    .irq_high_voltage(irq_high_voltage), .mode_strap_pin(mode_strap_pin),
    .test_fail(test_fail), .test_pass(test_pass), .user_mode(user_mode),
    .selfcheck_mode(selfcheck_mode), .bootstrap_mode(bootstrap_mode),
    .strap_released(strap_released), .start_vector(start_vector),
    .report_led_bit3(led3), .report_led_bit1(led1), .report_led_bit0(led0));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Settle well past the decision edge and the pin hand-over
  task automatic enter(logic irq, logic strap);
    u_board_model.power_up(irq, strap);
    repeat (6) @(negedge clk);
  endtask
  task automatic pulse_pass();
    test_pass = 1'b1;
    @(negedge clk);
    test_pass = 1'b0;
  endtask
  task automatic user_entry();
    enter(1'b0, 1'b1);
    check("user", 16'(user_mode), 16'h0001);
    check("check", 16'(selfcheck_mode), 16'h0000);
    check("freed", 16'(strap_released), 16'h0001);
    check("vector", start_vector, 16'h0000);
    pulse_pass();
    check("leds", 16'(leds), 16'(LED_ALL_OFF));
    enter(1'b1, 1'b0);
    check("strap low", 16'(user_mode), 16'h0001);
    check("strap low chk", 16'(selfcheck_mode), 16'h0000);
  endtask
  task automatic check_entry();
    enter(1'b1, 1'b1);
    check("check", 16'(selfcheck_mode), 16'h0001);
    check("boot", 16'(bootstrap_mode), 16'h0000);
    check("user", 16'(user_mode), 16'h0000);
    check("vector", start_vector, TEST_START);
    pulse_pass();
    check("flash on", 16'(leds), 16'(LED_ALL_ON));
    pulse_pass();
    check("flash off", 16'(leds), 16'(LED_ALL_OFF));
    check("held", 16'(selfcheck_mode), 16'h0001);
  endtask
  // Each code after a fresh entry, then prove the report freezes
  task automatic fail_codes();
    for (int k = 0; k < 4; k++) begin
      enter(1'b1, 1'b1);
      test_fail = {1'b1, fail_kind_t'(k)};
      @(negedge clk);
      test_fail = '0;
      check("code", 16'(leds), 16'(codes[k]));
      pulse_pass();
      check("frozen", 16'(leds), 16'(codes[k]));
    end
  endtask
  initial begin
    user_entry();
    check_entry();
    fail_codes();
    print_verdict();
  end
endmodule
